// ==== src/codec_host_fifo.sv ====
// Purpose: host data path of the image codec: fifo, checks, table store
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   register reads answer in the cycle after the read strobe
//
// What this block does
// RQ1 - accept images up to 1600 by 1200
// RQ2 - host keeps images above per-format minimum size
// RQ3 - decode 444/422/411/420, encode without 444, no RGB
// RQ4 - raw pass-through only in 422 and 420
// RQ5 - two encode and four decode quantization tables
// RQ6 - two AC and two DC Huffman tables
// RQ7 - up to 36 marker bytes inserted on encode
// RQ8 - decode recognises SOI SOF0 SOS DQT DHT DRI RST EOI
// RQ9 - fifo programmable up to 128K bytes; the 4-bit size field gives at most 64K bytes
// RQ10 - capacity is (size field plus one) times 4K
// RQ11 - readable fifo status and maskable fifo interrupts
// RQ12 - host drains fifo while encoding
// RQ13 - 32-bit entry moves as two 16-bit accesses
// RQ14 - host block reads sized from status
// RQ15 - host checks empty and threshold before single read
// RQ16 - read while empty terminates, fifo unchanged
// RQ17 - host fills fifo while decoding
// RQ18 - write while full terminates, data discarded
// RQ19 - in-order delivery, pointers wrap at capacity
`timescale 1ns/1ps
`include "codec_fifo_params.svh"
`default_nettype none
module codec_host_fifo
    import codec_fifo_pkg::*;
#(
    parameter int DEPTH = 32768            // fifo entries, 128K bytes
)(
    input  wire logic        clk_i,        // system clock
    input  wire logic        sys_rst_i,    // synchronous reset
    input  wire logic [11:0] reg_addr_i,   // register address
    input  wire logic [15:0] reg_wdata_i,  // register write data
    input  wire logic        reg_wr_i,     // write strobe
    input  wire logic        reg_rd_i,     // read strobe
    output logic      [15:0] reg_rdata_o,  // read data, one cycle later
    output logic             term_o,       // terminate cycle pulse
    output logic             irq_o,        // level interrupt
    input  wire logic        enc_valid_i,  // codec offers encoded word
    input  wire logic [31:0] enc_data_i,   // encoded word
    output logic             enc_ready_o,  // fifo can take a word
    output logic             dec_valid_o,  // fifo holds a word for codec
    output logic      [31:0] dec_data_o,   // head word
    input  wire logic        dec_ready_i,  // codec takes head word
    output logic             codec_go_o,   // codec run, config checked
    output logic             decode_o,     // 1 decode, 0 encode
    output logic      [1:0]  fmt_o,        // sampling format
    output logic             mark_ins_o,   // insert user marker bytes
    input  wire logic [9:0]  tab_addr_i,   // codec table byte address
    output logic      [7:0]  tab_data_o    // table byte, one cycle later
);
    localparam int PW = $clog2(DEPTH);     // pointer width
    fifo_word_t          mem [DEPTH];      // fifo storage
    logic [7:0]          tab [`TAB_BYTES]; // quant, huffman, marker bytes
    logic [PW-1:0]       wr_ptr_q, wr_ptr_d;
    logic [PW-1:0]       rd_ptr_q, rd_ptr_d;
    logic [15:0]         count_q, count_d;  // entries held
    logic [15:0]         cap;               // programmed capacity
    logic [`SIZE_FIELD_W-1:0] size_q, size_d;
    logic [15:0]         cfg_q, cfg_d;      // mode, format, start
    logic [15:0]         width_q, width_d;
    logic [15:0]         height_q, height_d;
    logic [15:0]         mask_q, mask_d;    // interrupt control
    logic [`INT_BITS-1:0] stat_q, stat_d;   // sticky events
    logic [15:0]         lo_q, lo_d;        // first half of a host write
    logic                wh_q, wh_d;        // host write half pending
    logic                rh_q, rh_d;        // host read half pending
    logic [15:0]         rdata_d;
    logic                term_d;
    logic [9:0]          taddr_q, taddr_d;  // host table pointer
    logic [7:0]          prev_q, prev_d;    // last stream byte
    logic [7:0]          mark_q, mark_d;    // last recognised marker code
    logic                mark_hit;
    logic                cfg_ok;            // image settings legal
    logic                push, pop;
    fifo_word_t          push_data, head_d;
    logic                empty, full;
    logic [1:0]          thr;
    logic                host_dw, host_dr;
    // capacity in entries, pointers wrap here
    assign cap = 16'(({12'h000, size_q} + 16'h0001) << `SIZE_SHIFT); // [RQ9] [RQ10]
    assign empty = (count_q == 16'h0000);
    assign full  = (count_q == cap);
    // threshold: 00 empty, 01 below half, 10 half or more, 11 full
    assign thr = empty ? 2'h0 : full ? 2'h3 : (count_q < (cap >> 1)) ? 2'h1 : 2'h2;
    assign host_dw = reg_wr_i && (reg_addr_i == `OFS_FIFO_DATA);
    assign host_dr = reg_rd_i && (reg_addr_i == `OFS_FIFO_DATA);
    // finds a known marker code after an FF byte
    function automatic logic is_marker(input logic [7:0] p, input logic [7:0] c);
        logic k;
        k = (c == 8'hD8) || (c == 8'hC0) || (c == 8'hDA) || (c == 8'hDB)
         || (c == 8'hC4) || (c == 8'hDD) || (c == 8'hD9)
         || (c[7:3] == 5'h1A);
        return (p == 8'hFF) && k;
    endfunction
    // image checks: size limit, format by direction, raw formats
    always_comb
    begin
        cfg_ok = (width_q != 16'h0000) && (height_q != 16'h0000)
              && (width_q <= `MAX_WIDTH) && (height_q <= `MAX_HEIGHT); // [RQ1]
        // encode has no 4:4:4
        if (!cfg_q[`CFG_DECODE] && (cfg_q[`CFG_FMT_HI:`CFG_FMT_LO] == FMT_444))
            cfg_ok = 1'b0; // [RQ3]
        // raw pass-through only 4:2:2 or 4:2:0
        if (cfg_q[`CFG_RAW] && (cfg_q[`CFG_FMT_HI:`CFG_FMT_LO] != FMT_422)
            && (cfg_q[`CFG_FMT_HI:`CFG_FMT_LO] != FMT_420))
            cfg_ok = 1'b0; // [RQ4]
    end
    // fifo push, pop and host access next state
    always_comb
    begin
        push      = 1'b0;
        pop       = 1'b0;
        push_data = enc_data_i;
        term_d    = 1'b0;
        lo_d      = lo_q;
        wh_d      = wh_q;
        rh_d      = rh_q;
        prev_d    = prev_q;
        mark_d    = mark_q;
        mark_hit  = 1'b0;
        if (!cfg_q[`CFG_DECODE])
        begin
            // encode: codec fills, host drains
            push = enc_valid_i && !full;
            if (host_dr)
            begin
                if (empty)
                    term_d = 1'b1; // [RQ16]
                else if (rh_q)
                begin
                    pop  = 1'b1; // [RQ12] [RQ13]
                    rh_d = 1'b0;
                end
                else
                    rh_d = 1'b1; // [RQ13]
            end
        end
        else
        begin
            // decode: host fills, codec drains
            pop       = dec_valid_o && dec_ready_i && !empty;
            push_data = {reg_wdata_i, lo_q};
            if (host_dw)
            begin
                if (!wh_q)
                begin
                    lo_d = reg_wdata_i; // [RQ13]
                    wh_d = 1'b1;
                end
                else if (full)
                begin
                    term_d = 1'b1; // [RQ18]
                    wh_d   = 1'b0;
                end
                else
                begin
                    push = 1'b1; // [RQ17]
                    wh_d = 1'b0;
                    // scan the four stream bytes for markers
                    for (int i = 0; i < 4; i++)
                    begin
                        if (is_marker(prev_d, push_data[8*i +: 8]))
                        begin
                            mark_hit = 1'b1; // [RQ8]
                            mark_d   = push_data[8*i +: 8];
                        end
                        prev_d = push_data[8*i +: 8];
                    end
                end
            end
        end
        // pointers wrap at programmed capacity, order kept
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        if (push)
            wr_ptr_d = (16'(wr_ptr_q) + 16'h0001 == cap) ? '0 : PW'(wr_ptr_q + 1'b1); // [RQ19]
        if (pop)
            rd_ptr_d = (16'(rd_ptr_q) + 16'h0001 == cap) ? '0 : PW'(rd_ptr_q + 1'b1); // [RQ19]
        count_d = count_q + {15'h0, push} - {15'h0, pop};
        // clearing or resizing empties the fifo
        if ((reg_wr_i && (reg_addr_i == `OFS_FIFO_SIZE))
            || (reg_wr_i && (reg_addr_i == `OFS_CODEC_CFG) && reg_wdata_i[`CFG_CLEAR]))
        begin
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            count_d  = 16'h0000;
            wh_d     = 1'b0;
            rh_d     = 1'b0;
        end
        // head word, bypass when written into the head slot
        head_d = (push && (wr_ptr_q == rd_ptr_d)) ? push_data : mem[rd_ptr_d];
    end
    // register file next state and read mux
    always_comb
    begin
        size_d   = size_q;
        cfg_d    = cfg_q;
        width_d  = width_q;
        height_d = height_q;
        mask_d   = mask_q;
        taddr_d  = taddr_q;
        rdata_d  = 16'h0000;
        stat_d   = stat_q;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `OFS_INT_STATUS:  stat_d  = stat_q & ~reg_wdata_i[`INT_BITS-1:0];
                `OFS_INT_CONTROL: mask_d  = reg_wdata_i; // [RQ11]
                `OFS_FIFO_SIZE:   size_d  = reg_wdata_i[`SIZE_FIELD_W-1:0]; // [RQ9]
                `OFS_CODEC_CFG:   cfg_d   = {9'h000, reg_wdata_i[6], 1'b0, reg_wdata_i[4:0]};
                `OFS_IMG_WIDTH:   width_d = reg_wdata_i;
                `OFS_IMG_HEIGHT:  height_d = reg_wdata_i;
                `OFS_TAB_ADDR:    taddr_d = reg_wdata_i[9:0];
                `OFS_TAB_DATA:    taddr_d = taddr_q + 10'h001;
                default:          ;
            endcase
        end
        // events set after the clear, so a set wins
        stat_d[`INT_EMPTY]   = stat_d[`INT_EMPTY] | (count_d == 16'h0000);
        stat_d[`INT_FULL]    = stat_d[`INT_FULL] | (count_d == cap);
        stat_d[`INT_THRESH]  = stat_d[`INT_THRESH] | (count_d >= (cap >> 1));
        stat_d[`INT_TERM]    = stat_d[`INT_TERM] | term_d;
        stat_d[`INT_CFG_ERR] = stat_d[`INT_CFG_ERR] | (cfg_q[`CFG_START] && !cfg_ok);
        stat_d[`INT_MARKER]  = stat_d[`INT_MARKER] | mark_hit;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `OFS_INT_STATUS:  rdata_d = {10'h000, stat_q};
                `OFS_INT_CONTROL: rdata_d = mask_q;
                `OFS_FIFO_STATUS: rdata_d = {12'h000, thr, full, empty}; // [RQ11] [RQ14] [RQ15]
                `OFS_FIFO_SIZE:   rdata_d = {12'h000, size_q};
                `OFS_FIFO_DATA:   rdata_d = (cfg_q[`CFG_DECODE] || empty) ? 16'h0000
                                          : (rh_q ? dec_data_o[31:16] : dec_data_o[15:0]);
                `OFS_FIFO_LEVEL:  rdata_d = count_q; // [RQ14]
                `OFS_CODEC_CFG:   rdata_d = cfg_q;
                `OFS_IMG_WIDTH:   rdata_d = width_q;
                `OFS_IMG_HEIGHT:  rdata_d = height_q;
                `OFS_TAB_ADDR:    rdata_d = {6'h00, taddr_q};
                `OFS_TAB_DATA:    rdata_d = {8'h00, tab[taddr_q]};
                `OFS_LAST_MARKER: rdata_d = {8'h00, mark_q};
                default:          rdata_d = 16'h0000;
            endcase
        end
    end
    // fifo storage, table store writes, codec table read one cycle later
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr_q] <= push_data;
        // table store: quant 4x64, dc 2x28, ac 2x178, markers 36
        if (reg_wr_i && (reg_addr_i == `OFS_TAB_DATA) && (32'(taddr_q) < `TAB_BYTES))
            tab[taddr_q] <= reg_wdata_i[7:0]; // [RQ5] [RQ6] [RQ7]
        // encode folds quant tables 2 and 3 onto 0 and 1
        if (!cfg_q[`CFG_DECODE] && (tab_addr_i < `TAB_HDC_BASE))
            tab_data_o <= tab[{3'h0, tab_addr_i[6:0]}]; // [RQ5]
        else if (32'(tab_addr_i) < `TAB_BYTES)
            tab_data_o <= tab[tab_addr_i]; // [RQ6] [RQ7]
        else
            tab_data_o <= 8'h00;
    end

    // state registers
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr_q    <= '0;
            rd_ptr_q    <= '0;
            count_q     <= 16'h0000;
            size_q      <= `RST_SIZE;
            cfg_q       <= `RST_CFG;
            width_q     <= 16'h0000;
            height_q    <= 16'h0000;
            mask_q      <= 16'h0000;
            stat_q      <= '0;
            lo_q        <= 16'h0000;
            wh_q        <= 1'b0;
            rh_q        <= 1'b0;
            taddr_q     <= 10'h000;
            prev_q      <= 8'h00;
            mark_q      <= 8'h00;
            reg_rdata_o <= 16'h0000;
            term_o      <= 1'b0;
            irq_o       <= 1'b0;
            enc_ready_o <= 1'b0;
            dec_valid_o <= 1'b0;
            dec_data_o  <= 32'h0000_0000;
            codec_go_o  <= 1'b0;
            decode_o    <= 1'b0;
            fmt_o       <= 2'h0;
            mark_ins_o  <= 1'b0;
        end
        else
        begin
            wr_ptr_q    <= wr_ptr_d;
            rd_ptr_q    <= rd_ptr_d;
            count_q     <= count_d;
            size_q      <= size_d;
            cfg_q       <= cfg_d;
            width_q     <= width_d;
            height_q    <= height_d;
            mask_q      <= mask_d;
            stat_q      <= stat_d;
            lo_q        <= lo_d;
            wh_q        <= wh_d;
            rh_q        <= rh_d;
            taddr_q     <= taddr_d;
            prev_q      <= prev_d;
            mark_q      <= mark_d;
            reg_rdata_o <= rdata_d;
            term_o      <= term_d;
            irq_o       <= |(stat_d & mask_q[`INT_BITS-1:0]); // [RQ11]
            enc_ready_o <= !cfg_d[`CFG_DECODE] && (count_d != cap);
            dec_valid_o <= cfg_d[`CFG_DECODE] && (count_d != 16'h0000);
            dec_data_o  <= head_d;
            codec_go_o  <= cfg_q[`CFG_START] && cfg_ok; // [RQ1] [RQ3] [RQ4]
            decode_o    <= cfg_q[`CFG_DECODE];
            fmt_o       <= cfg_q[`CFG_FMT_HI:`CFG_FMT_LO];
            mark_ins_o  <= cfg_q[`CFG_MARK_INS] && !cfg_q[`CFG_DECODE]; // [RQ7]
        end
    end

    // read while empty: terminate, count moves only by a codec push
    a_empty_read_term: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ16]
        (host_dr && !cfg_q[`CFG_DECODE] && empty)
        |=> (term_o && count_q == $past(count_q) + {15'h0, $past(push)} && $stable(rh_q)))
        else $error("empty read did not terminate");
    // write while full: terminate, count moves only by a codec pop
    a_full_write_term: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ18]
        (host_dw && cfg_q[`CFG_DECODE] && wh_q && full)
        |=> (term_o && count_q == $past(count_q) - {15'h0, $past(pop)}))
        else $error("full write did not terminate");
    // second write half pushes one entry
    a_pair_push: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ13]
        (host_dw && cfg_q[`CFG_DECODE] && wh_q && !full && !pop)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("write pair did not push");
    // first read half never pops
    a_half_nopop: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ13]
        (host_dr && !cfg_q[`CFG_DECODE] && !empty && !rh_q && !push) |=> $stable(count_q) && rh_q)
        else $error("first read half popped");
    // occupancy never passes capacity
    a_count_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ10] [RQ19]
        (count_q <= cap) && (16'(wr_ptr_q) < cap) && (16'(rd_ptr_q) < cap))
        else $error("fifo beyond capacity");
    // status register shows empty and full
    a_status_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ11] [RQ15]
        (reg_rd_i && reg_addr_i == `OFS_FIFO_STATUS)
        |=> (reg_rdata_o[1:0] == $past({full, empty})))
        else $error("fifo status wrong");
    // oversize image keeps codec stopped
    a_size_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ1]
        (width_q > `MAX_WIDTH || height_q > `MAX_HEIGHT) |=> !codec_go_o)
        else $error("oversize image started");
    // encode never runs in 4:4:4
    a_enc_444: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ3]
        (codec_go_o && !decode_o) |-> (fmt_o != FMT_444))
        else $error("encode started in 4:4:4");
    // interrupt follows masked status
    a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ11]
        ##1 (irq_o == |($past(stat_d) & $past(mask_q[`INT_BITS-1:0]))))
        else $error("interrupt level wrong");
endmodule // codec_host_fifo
`default_nettype wire

// ==== src/codec_fifo_params.svh ====
// Purpose: offsets, field positions, reset values and limits of the codec host path
// Assumes: included by the design file and by the bench
// Notes:   register offsets are the 12-bit port addresses
`ifndef CODEC_FIFO_PARAMS_SVH
`define CODEC_FIFO_PARAMS_SVH
// register offsets
`define OFS_INT_STATUS   12'h982
`define OFS_INT_CONTROL  12'h986
`define OFS_FIFO_STATUS  12'h9A2
`define OFS_FIFO_SIZE    12'h9A4
`define OFS_FIFO_DATA    12'h9A6
`define OFS_FIFO_LEVEL   12'h9A8
`define OFS_CODEC_CFG    12'h9AA
`define OFS_IMG_WIDTH    12'h9AC
`define OFS_IMG_HEIGHT   12'h9AE
`define OFS_TAB_ADDR     12'h9B0
`define OFS_TAB_DATA     12'h9B2
`define OFS_LAST_MARKER  12'h9B4
// image limits
`define MAX_WIDTH        16'h0640
`define MAX_HEIGHT       16'h04B0
// fifo size: (field + 1) * 4K bytes, one entry is 4 bytes
`define SIZE_FIELD_W     4
`define SIZE_SHIFT       10
// config register fields
`define CFG_DECODE       0
`define CFG_FMT_LO       1
`define CFG_FMT_HI       2
`define CFG_RAW          3
`define CFG_START        4
`define CFG_CLEAR        5
`define CFG_MARK_INS     6
// interrupt / status bit positions
`define INT_EMPTY        0
`define INT_FULL         1
`define INT_THRESH       2
`define INT_TERM         3
`define INT_CFG_ERR      4
`define INT_MARKER       5
`define INT_BITS         6
// table byte store layout
`define TAB_Q_BASE       10'h000
`define TAB_HDC_BASE     10'h100
`define TAB_HAC_BASE     10'h138
`define TAB_MRK_BASE     10'h29C
`define TAB_BYTES        704
`define MRK_BYTES        36
// reset values
`define RST_SIZE         4'h0
`define RST_CFG          16'h0000
`endif

// ==== src/codec_fifo_pkg.sv ====
// Purpose: shared types of the codec host path
// Assumes: constants come from codec_fifo_params.svh
// Notes:   types only
package codec_fifo_pkg;
    // sampling formats as coded in the config register
    typedef enum logic [1:0] {FMT_444, FMT_422, FMT_420, FMT_411} yuv_fmt_e;
    // fifo word
    typedef logic [31:0] fifo_word_t;
endpackage

// ==== verif/codec_model.sv ====
// Purpose: codec side of the host fifo, offers encoded words and takes decoded ones
// Assumes: one clock, synchronous active-high reset
// Notes:   the offered word is inverted while nothing is on offer
`timescale 1ns/1ps
`default_nettype none
module codec_model (
    input  wire logic        clk_i,     // system clock
    input  wire logic        sys_rst_i, // synchronous reset
    input  wire logic [15:0] npush_i,   // words to offer in encode
    input  wire logic        stall_i,   // holds off decode pops
    output logic             ev_o,      // word on offer
    output logic      [31:0] ed_o,      // offered word
    input  wire logic        er_i,      // fifo takes a word
    input  wire logic        dv_i,      // fifo head valid
    input  wire logic [31:0] dd_i,      // fifo head word
    output logic             dr_o,      // model takes the head
    output logic      [15:0] npop_o,    // words taken so far
    output logic      [31:0] first_o,   // first word taken
    output logic      [31:0] last_o     // latest word taken
);
    logic [15:0] k_q;                   // words pushed so far
    logic [31:0] pat;                   // next word to offer
    assign pat = {16'hB000 + k_q, 16'hA000 + k_q};
    assign ev_o = (k_q < npush_i);
    // never leave the last word standing on the bus
    assign ed_o = ev_o ? pat : ~pat;
    assign dr_o = !stall_i;
    // offer held until taken, pops logged in order
    always @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            k_q <= 16'h0000;
            npop_o <= 16'h0000;
        end
        else
        begin
            if (ev_o && er_i)
                k_q <= k_q + 16'h0001;
            if (dv_i && dr_o)
            begin
                if (npop_o == 16'h0000)
                    first_o <= dd_i;
                last_o <= dd_i;
                npop_o <= npop_o + 16'h0001;
            end
        end
    end
endmodule // codec_model
`default_nettype wire

// ==== verif/tb_codec_host_fifo.sv ====
// Purpose: self-checking bench of the codec host fifo
// Assumes: codec_model plays the codec, this bench plays the host
// Notes:   size field 0 gives 1024 entries, storage cut to 2048
`timescale 1ns/1ps
`include "codec_fifo_params.svh"
`default_nettype none
module tb_codec_host_fifo;
    logic        clk_i = 1'b0;          // system clock
    logic        sys_rst_i = 1'b1;      // reset
    logic [11:0] addr = 12'h000;        // register bus
    logic [15:0] wdat = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdat;
    logic        term, irq, ev, er, dv, dr, go;
    logic [31:0] ed, dd, first, last;
    logic [9:0]  taddr = 10'h000;       // codec table address
    logic [7:0]  tdat;
    logic        dec_o, mi;             // config mirrors
    logic [1:0]  fm;
    logic [15:0] npush = 16'h0000;      // model controls
    logic        stall = 1'b1;
    logic [15:0] npop;
    logic [15:0] v;                     // last read value
    logic        t;                     // last terminate flag
    int          miscompares = 0;
    int          n_compared = 0;
    int          i;
    logic [15:0] cc[7] = '{16'h0012, 16'h0010, 16'h0011, 16'h0016, 16'h001E, 16'h001C, 16'h0012};
    logic [15:0] cw[7] = '{16'h0640, 16'h0640, 16'h0640, 16'h0640, 16'h0640, 16'h0640, 16'h0641};
    logic        cg[7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [9:0]  ta[4] = '{10'h0FF, 10'h29B, 10'h2BF, 10'h07F};
    always #20 clk_i = ~clk_i;
    codec_host_fifo #(.DEPTH(2048)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .term_o(term), .irq_o(irq), .enc_valid_i(ev),
        .enc_data_i(ed), .enc_ready_o(er), .dec_valid_o(dv), .dec_data_o(dd),
        .dec_ready_i(dr), .codec_go_o(go), .decode_o(dec_o), .fmt_o(fm), .mark_ins_o(mi),
        .tab_addr_i(taddr), .tab_data_o(tdat));
    codec_model M (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .npush_i(npush),
        .stall_i(stall), .ev_o(ev), .ed_o(ed), .er_i(er), .dv_i(dv), .dd_i(dd),
        .dr_o(dr), .npop_o(npop), .first_o(first), .last_o(last));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-cycle write, terminate sampled in the next cycle
    task automatic wreg(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        #1 t = term;
    endtask
    // one-cycle read, data and terminate in the next cycle
    task automatic rreg(input logic [11:0] a);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 v = rdat;
        t = term;
    endtask
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rreg(`OFS_FIFO_STATUS);
        chk(v, 16'h0001);
        wreg(`OFS_FIFO_SIZE, 16'h000F);
        rreg(`OFS_FIFO_SIZE);
        chk(v, 16'h000F);
        wreg(`OFS_FIFO_SIZE, 16'h0000);
        wreg(`OFS_IMG_HEIGHT, `MAX_HEIGHT);
        for (i = 0; i < 7; i++)
        begin
            wreg(`OFS_IMG_WIDTH, cw[i]);
            wreg(`OFS_CODEC_CFG, cc[i]);
            repeat (2) @(posedge clk_i);
            chk(go, cg[i]);
        end
        // encode: codec fills, host drains a sized block
        wreg(`OFS_CODEC_CFG, 16'h0052);
        npush <= 16'h0003;
        repeat (10) @(posedge clk_i);
        chk({mi, fm, dec_o}, 4'hA);
        rreg(`OFS_FIFO_LEVEL);
        chk(v, 16'h0003);
        rreg(`OFS_FIFO_STATUS);
        chk(v, 16'h0004);
        for (i = 0; i < 3; i++)
        begin
            rreg(`OFS_FIFO_DATA);
            chk(v, 16'hA000 + i);
            rreg(`OFS_FIFO_DATA);
            chk(v, 16'hB000 + i);
        end
        rreg(`OFS_FIFO_DATA);
        chk({t, v}, 32'h00010000);
        rreg(`OFS_FIFO_LEVEL);
        chk(v, 16'h0000);
        // terminate event through mask and clear
        chk(irq, 1'b0);
        wreg(`OFS_INT_CONTROL, 16'h0008);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b1);
        wreg(`OFS_INT_STATUS, 16'h0008);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b0);
        // decode: host fills to the brim while the codec stalls
        wreg(`OFS_FIFO_SIZE, 16'h0000);
        wreg(`OFS_CODEC_CFG, 16'h0013);
        for (i = 0; i < 1024; i++)
        begin
            wreg(`OFS_FIFO_DATA, 16'h5000 + i);
            wreg(`OFS_FIFO_DATA, 16'h6000 + i);
        end
        rreg(`OFS_FIFO_STATUS);
        chk(v, 16'h000E);
        wreg(`OFS_FIFO_DATA, 16'hDEAD);
        wreg(`OFS_FIFO_DATA, 16'hBEEF);
        chk(t, 1'b1);
        rreg(`OFS_FIFO_LEVEL);
        chk(v, 16'h0400);
        stall <= 1'b0;
        for (i = 0; i < 2000 && npop < 16'd1024; i++)
            @(posedge clk_i);
        chk(npop, 16'd1024);
        chk(first, 32'h60005000);
        chk(last, 32'h63FF53FF);
        // stream bytes FF D8 make a start-of-image marker
        wreg(`OFS_FIFO_DATA, 16'hD8FF);
        wreg(`OFS_FIFO_DATA, 16'h0000);
        rreg(`OFS_LAST_MARKER);
        chk(v, 16'h00D8);
        // table bytes at the last quant, AC and marker places
        for (i = 0; i < 4; i++)
        begin
            wreg(`OFS_TAB_ADDR, {6'h00, ta[i]});
            wreg(`OFS_TAB_DATA, 16'h003C + i);
            @(posedge clk_i);
            taddr <= ta[i];
            @(posedge clk_i);
            #1 chk(tdat, 8'h3C + i);
        end
        // encode: quant table 3 address folds onto table 1
        wreg(`OFS_CODEC_CFG, 16'h0012);
        @(posedge clk_i);
        taddr <= 10'h0FF;
        @(posedge clk_i);
        #1 chk(tdat, 8'h3F);
        test_done;
    end
    // watchdog against a hang
    initial
    begin
        #(40 * 40000);
        miscompares++;
        test_done;
    end
endmodule // tb_codec_host_fifo
`default_nettype wire
